/* File: core/sfr_pkg.sv */
// ==========================================================================
// Shared constants for the serial flash read unit.
package sfr_pkg;

  // ========================================================================
  // Array geometry.
  localparam int PAGE_BYTES = 528;
  localparam logic [9:0] LAST_BYTE = 10'h20f;
  localparam logic [11:0] LAST_PAGE = 12'hfff;
  localparam int PAGE_W = 12;
  localparam int BYTE_W = 10;

  // ========================================================================
  // Read opcodes, two accepted values for each command.
  localparam logic [7:0] OP_ARRAY_A = 8'h68;
  localparam logic [7:0] OP_ARRAY_B = 8'he8;
  localparam logic [7:0] OP_PAGE_A = 8'h52;
  localparam logic [7:0] OP_PAGE_B = 8'hd2;
  localparam logic [7:0] OP_BUF1_A = 8'h54;
  localparam logic [7:0] OP_BUF1_B = 8'hd4;
  localparam logic [7:0] OP_BUF2_A = 8'h56;
  localparam logic [7:0] OP_BUF2_B = 8'hd6;
  localparam logic [7:0] OP_STAT_A = 8'h57;
  localparam logic [7:0] OP_STAT_B = 8'hd7;

  // ========================================================================
  // Header framing in serial clock edges counted from the frame start.
  localparam logic [6:0] CNT_OPCODE_LAST = 7'h07;
  localparam logic [6:0] CNT_ADDR_LAST = 7'h1f;
  localparam logic [6:0] CNT_MEM_DATA = 7'h40;
  localparam logic [6:0] CNT_BUF_DATA = 7'h28;
  localparam logic [6:0] CNT_STAT_DATA = 7'h08;
  localparam logic [6:0] CNT_SAT = 7'h40;

  // Address field positions inside the 24 address bits.
  localparam int PAGE_LSB = 10;
  localparam int BYTE_LSB = 0;

  // ========================================================================
  // State byte layout.
  localparam int ST_READY = 7;
  localparam int ST_COMP = 6;
  localparam logic [2:0] ST_RESERVED_VAL = 3'h0;

  // Staging FIFO shape.
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  // ========================================================================
  // Decoded command and byte fetcher states.
  typedef enum logic [2:0] {
    CMD_NONE, CMD_ARRAY, CMD_PAGE, CMD_BUF1, CMD_BUF2, CMD_STATUS, CMD_IGNORE
  } sfr_cmd_t;

  typedef enum logic [1:0] {F_IDLE, F_ISSUE, F_PUSH} sfr_fetch_t;

endpackage

/* File: core/sfr_fifo_if.sv */
`timescale 1ns/1ns
// ==========================================================================
// Carrier between the sequencer and its staging FIFO.
interface sfr_fifo_if #(parameter int W = 8);
  logic flush;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport user (output flush, output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
  modport store (input flush, input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
endinterface

/* File: core/sfr_fifo.sv */
`timescale 1ns/1ns
// ==========================================================================
// Synchronous FIFO with valid/ready on both sides and a flush.
module sfr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill and drain sides.
  sfr_fifo_if.store f
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [0:D-1];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Pointers carry one extra bit to tell full from empty.
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign push = f.in_valid && !full;
  assign pop = f.out_ready && !empty;
  assign f.in_ready = !full;
  assign f.out_valid = !empty;
  assign f.out_data = mem_q[rd_q[AW-1:0]];

  // Pointer update; flush empties the store at once.
  always_ff @(posedge clk) begin
    if (!rst_n || f.flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= f.in_data;
    end
  end
endmodule

/* File: core/sfr_read_unit.sv */
`timescale 1ns/1ns
// What this block does
// - Array read wraps from the last array bit to page zero with no pause.
// - Chip select rising ends any read and floats the serial output.
// - Array reads take main memory directly and never touch the buffers.
// - Page read starts on two opcodes: opcode, 24 address, 32 dummy bits.
// - Address holds two reserved bits, 12-bit page, 10-bit byte offset.
// - Page read reaches any page directly and leaves buffers unchanged.
// - After the 32 dummy bits every clock shifts out one data bit.
// - Page read wraps at page end to the start of the same page.
// - Two opcodes read buffer one, two other opcodes read buffer two.
// - Buffer read: opcode, 14 dummy, 10-bit offset, 8 dummy bits.
// - Buffer read wraps after byte 527 to byte zero of that buffer.
// - State byte read shifts eight bits MSB first right after the opcode.
// - State byte repeats from bit 7 with fresh values while clocked.
// - Bits 2..0 reserved; upper five bits carry device information.
// - With the clock halted at bit 7 the live ready flag is driven.
// - Busy is held during transfer, compare, program and rewrite operations.
// - Bits 5..3 hold a fixed density code.
// - Array read uses opcode, 24 address and 32 dummy bits.
// - Everything on the serial link travels MSB first.
module sfr_read_unit
  import sfr_pkg::*;
#(
  // Density code; this default is arbitrary.
  parameter logic [2:0] DENSITY_CODE = 3'h3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link pins.
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_q,
  output logic so_oe_q,
  // Main memory read port, data taken at the clock edge that ends the strobe cycle.
  output logic mem_rd_q,
  output logic [PAGE_W-1:0] mem_page_q,
  output logic [BYTE_W-1:0] mem_byte_q,
  input wire logic [7:0] mem_rdata_i,
  // Buffer load port from the write side of the device.
  input wire logic buf_wr_i,
  input wire logic buf_wsel_i,
  input wire logic [BYTE_W-1:0] buf_waddr_i,
  input wire logic [7:0] buf_wdata_i,
  // Operation state from the program and erase logic.
  input wire logic busy_i,
  input wire logic comp_mismatch_i
);

  // ========================================================================
  // Pin synchronisers.
  logic [1:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] si_sync_q;
  logic frame_off;
  logic sck_rise;
  logic sck_fall;
  logic si_bit;

  // Two flops per pin; a third stage on the clock keeps its last level for edge finding.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 3'h0;
      si_sync_q <= 2'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n_i};
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      si_sync_q <= {si_sync_q[0], si_i};
    end
  end

  // Chip select high is a frame reset for the header, fetch, FIFO and output state below.
  // The select acts on its level, so it needs no edge stage of its own.
  assign frame_off = cs_sync_q[1];
  assign sck_rise = sck_sync_q[1] && !sck_sync_q[2];
  assign sck_fall = !sck_sync_q[1] && sck_sync_q[2];
  assign si_bit = si_sync_q[1];

  // ========================================================================
  // Header capture.
  logic [6:0] cnt_q;
  logic [31:0] hdr_q;
  logic [31:0] hdr_d;
  sfr_cmd_t cmd_q;
  sfr_cmd_t cmd_d;
  logic data_q;
  logic [6:0] data_start;

  assign hdr_d = {hdr_q[30:0], si_bit};

  // Opcode decode of the first eight bits.
  always_comb begin
    case (hdr_d[7:0])
      OP_ARRAY_A, OP_ARRAY_B: cmd_d = CMD_ARRAY;
      OP_PAGE_A, OP_PAGE_B: cmd_d = CMD_PAGE;
      OP_BUF1_A, OP_BUF1_B: cmd_d = CMD_BUF1;
      OP_BUF2_A, OP_BUF2_B: cmd_d = CMD_BUF2;
      OP_STAT_A, OP_STAT_B: cmd_d = CMD_STATUS;
      default: cmd_d = CMD_IGNORE;
    endcase
  end

  // Edge count at which output starts for array, page and buffer reads.
  always_comb begin
    case (cmd_q)
      CMD_ARRAY, CMD_PAGE: data_start = CNT_MEM_DATA;
      CMD_BUF1, CMD_BUF2: data_start = CNT_BUF_DATA;
      default: data_start = CNT_SAT;
    endcase
  end

  // Bits are shifted in MSB first on each rising serial clock edge.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_off) begin
      cnt_q <= 7'h00;
      hdr_q <= 32'h0;
    end else if (sck_rise) begin
      hdr_q <= hdr_d;
      if (cnt_q != CNT_SAT) begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  // Command and data phase flags; a rising select clears both.
  // Unknown opcodes never open the data phase, so the pin stays released.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_off) begin
      cmd_q <= CMD_NONE;
      data_q <= 1'b0;
    end else if (sck_rise) begin
      if (cnt_q == CNT_OPCODE_LAST) begin
        cmd_q <= cmd_d;
        data_q <= (cmd_d == CMD_STATUS);
      end else if (cmd_q inside {CMD_ARRAY, CMD_PAGE, CMD_BUF1, CMD_BUF2}
          && cnt_q + 7'h01 == data_start) begin
        data_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Byte fetcher feeding the staging FIFO.
  sfr_fifo_if #(.W(FIFO_W)) fq ();

  sfr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .f(fq)
  );

  sfr_fetch_t fst_q;
  logic [PAGE_W-1:0] page_q;
  logic [BYTE_W-1:0] byte_q;
  logic src_buf_q;
  logic buf_sel_q;
  logic [7:0] buf_rdata_q;
  logic addr_done;
  logic [7:0] buf1_mem [0:PAGE_BYTES-1];
  logic [7:0] buf2_mem [0:PAGE_BYTES-1];
  logic [BYTE_W-1:0] buf_ridx;

  assign addr_done = sck_rise && (cnt_q == CNT_ADDR_LAST);
  assign buf_ridx = (byte_q > LAST_BYTE) ? '0 : byte_q;
  assign fq.flush = frame_off;
  assign fq.in_valid = (fst_q == F_PUSH);
  assign fq.in_data = src_buf_q ? buf_rdata_q : mem_rdata_i;

  // Prefetch runs well ahead of the link, so page crossings need no pause.
  // Fetch sequence: issue one read, push its byte, step the address.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_off) begin
      fst_q <= F_IDLE;
    end else begin
      case (fst_q)
        F_IDLE: begin
          if (addr_done && cmd_q inside {CMD_ARRAY, CMD_PAGE, CMD_BUF1, CMD_BUF2}) begin
            fst_q <= F_ISSUE;
          end
        end
        F_ISSUE: begin
          if (fq.in_ready) begin
            fst_q <= F_PUSH;
          end
        end
        F_PUSH: fst_q <= F_ISSUE;
        default: fst_q <= F_IDLE;
      endcase
    end
  end

  // Address capture and stepping with the three wrap behaviours.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_q <= '0;
      byte_q <= '0;
      src_buf_q <= 1'b0;
      buf_sel_q <= 1'b0;
    end else if (fst_q == F_IDLE && addr_done) begin
      page_q <= hdr_d[PAGE_LSB +: PAGE_W];
      byte_q <= hdr_d[BYTE_LSB +: BYTE_W];
      src_buf_q <= (cmd_q == CMD_BUF1) || (cmd_q == CMD_BUF2);
      buf_sel_q <= (cmd_q == CMD_BUF2);
    end else if (fst_q == F_PUSH) begin
      if (byte_q >= LAST_BYTE) begin
        byte_q <= '0;
        if (cmd_q == CMD_ARRAY) begin
          page_q <= (page_q == LAST_PAGE) ? '0 : page_q + 12'h001;
        end
      end else begin
        byte_q <= byte_q + 10'h001;
      end
    end
  end

  // Main memory strobe; array and page reads go straight to memory.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd_q <= 1'b0;
      mem_page_q <= '0;
      mem_byte_q <= '0;
    end else begin
      mem_rd_q <= (fst_q == F_ISSUE) && fq.in_ready && !src_buf_q && !frame_off;
      mem_page_q <= page_q;
      mem_byte_q <= byte_q;
    end
  end

  // Buffers are written only by the load port, never by a read.
  always_ff @(posedge clk) begin
    if (buf_wr_i && buf_waddr_i <= LAST_BYTE) begin
      if (buf_wsel_i) begin
        buf2_mem[buf_waddr_i] <= buf_wdata_i;
      end else begin
        buf1_mem[buf_waddr_i] <= buf_wdata_i;
      end
    end
  end

  // Buffer read, one cycle ahead of the push.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_rdata_q <= 8'h00;
    end else if (fst_q == F_ISSUE) begin
      buf_rdata_q <= buf_sel_q ? buf2_mem[buf_ridx] : buf1_mem[buf_ridx];
    end
  end

  // ========================================================================
  // Serial output.
  logic [7:0] live_state;
  logic [7:0] out_byte_q;
  logic [2:0] bitpos_q;
  logic shown_q;
  logic next_byte;

  // State byte assembled live each cycle from busy, compare and density.
  // Reserved bits drive zero; hosts should not rely on their value.
  assign live_state = {!busy_i, comp_mismatch_i, DENSITY_CODE, ST_RESERVED_VAL};
  assign next_byte = sck_fall && data_q && (!shown_q || bitpos_q == 3'h0);
  assign fq.out_ready = next_byte && (cmd_q != CMD_STATUS) && !frame_off;

  // Bit pointer steps on falling edges and reloads after bit 0.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_off) begin
      bitpos_q <= 3'h7;
      shown_q <= 1'b0;
      out_byte_q <= 8'h00;
    end else if (sck_fall && data_q) begin
      shown_q <= 1'b1;
      if (next_byte) begin
        bitpos_q <= 3'h7;
        out_byte_q <= fq.out_valid ? fq.out_data : 8'h00;
      end else begin
        bitpos_q <= bitpos_q - 3'h1;
      end
    end
  end

  // Pin drive: the state bit follows the live value, so a halted clock still polls.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_off) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= shown_q;
      if (cmd_q == CMD_STATUS) begin
        so_q <= live_state[bitpos_q];
      end else begin
        so_q <= out_byte_q[bitpos_q];
      end
    end
  end

endmodule

/* File: testbench/sfr_read_unit_asserts.sv */
`timescale 1ns/1ns
// ====================
// Port-level checks of the serial flash read unit.
module sfr_read_unit_asserts
  import sfr_pkg::*;
(
  // Clock and reset.
  input logic clk,
  input logic rst_n,
  // Serial link pins.
  input logic cs_n_i,
  input logic sck_i,
  input logic si_i,
  input logic so_q,
  input logic so_oe_q,
  // Main memory read port.
  input logic mem_rd_q,
  input logic [PAGE_W-1:0] mem_page_q,
  input logic [BYTE_W-1:0] mem_byte_q,
  input logic [7:0] mem_rdata_i,
  // Buffer load port.
  input logic buf_wr_i,
  input logic buf_wsel_i,
  input logic [BYTE_W-1:0] buf_waddr_i,
  input logic [7:0] buf_wdata_i,
  // Operation state.
  input logic busy_i,
  input logic comp_mismatch_i
);
  logic have_q;
  logic [BYTE_W-1:0] lb_q;
  logic [PAGE_W-1:0] lp_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Marks that the current frame already made a fetch.
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n_i) begin
      have_q <= 1'b0;
    end else if (mem_rd_q) begin
      have_q <= 1'b1;
    end
  end

  // Keeps the address of the latest fetch for step checks.
  always_ff @(posedge clk) begin
    if (mem_rd_q) begin
      lb_q <= mem_byte_q;
      lp_q <= mem_page_q;
    end
  end

  // ====================
  // Assertions.
  a_quiet_after_reset: assert property ($rose(rst_n) |-> !so_oe_q && !so_q && !mem_rd_q)
    else $error("outputs active right after reset");
  a_oe_idle_off: assert property (cs_n_i [*6] |-> !so_oe_q)
    else $error("serial output enabled while deselected");
  a_oe_drop_cause: assert property ($fell(so_oe_q) |-> $past(cs_n_i))
    else $error("serial output released inside a frame");
  a_oe_after_header: assert property ($rose(so_oe_q) |-> !cs_n_i && !$past(cs_n_i, 30))
    else $error("serial output enabled too early in a frame");
  a_byte_step: assert property (mem_rd_q && have_q |->
      mem_byte_q == ((lb_q >= LAST_BYTE) ? '0 : lb_q + 1'b1))
    else $error("fetch byte did not step by one");
  a_page_step: assert property (mem_rd_q && have_q |-> mem_page_q == lp_q ||
      (lb_q >= LAST_BYTE && mem_page_q == lp_q + 1'b1))
    else $error("fetch page changed away from a page end");
  a_rd_idle_off: assert property (cs_n_i [*8] |-> !mem_rd_q)
    else $error("memory fetch while deselected");
  a_first_rd_late: assert property (mem_rd_q && !have_q && !cs_n_i |-> !$past(cs_n_i, 60))
    else $error("memory fetch before the header was complete");

  // Main scenarios reached.
  c_output_on: cover property ($rose(so_oe_q));
  c_page_end: cover property (mem_rd_q && have_q && lb_q == LAST_BYTE);
  c_array_wrap: cover property (mem_rd_q && have_q && lp_q == LAST_PAGE && mem_page_q == '0);
endmodule

bind sfr_read_unit sfr_read_unit_asserts u_chk (.clk, .rst_n, .cs_n_i, .sck_i, .si_i, .so_q,
  .so_oe_q, .mem_rd_q, .mem_page_q, .mem_byte_q, .mem_rdata_i, .buf_wr_i, .buf_wsel_i,
  .buf_waddr_i, .buf_wdata_i, .busy_i, .comp_mismatch_i);

/* File: testbench/sfr_host.sv */
`timescale 1ns/1ns
// ====================
// Serial bus master that frames commands for the read unit.
module sfr_host (
  // Clock.
  input wire logic clk,
  // Serial link.
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  // Idle link: deselected with the clock parked low.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Waits n falling edges of the system clock.
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Selects the device; it stays selected until stop.
  task automatic start();
    cs_n = 1'b0;
    gap(4);
  endtask

  // Shifts n bits out and in, sampling the output at the end of the high phase.
  task automatic xfer(input int n, input logic [7:0] o, output logic [7:0] i);
    i = 8'h00;
    for (int k = 7; k > 7 - n; k--) begin
      sck = 1'b0;
      si = o[k];
      gap(4);
      sck = 1'b1;
      gap(4);
      i[k] = so;
    end
  endtask

  // Parks the clock, deselects and lets the data line wander.
  task automatic stop();
    sck = 1'b0;
    gap(4);
    cs_n = 1'b1;
    si = ~si;
    gap(6);
  endtask
endmodule

/* File: testbench/sfr_read_unit_tb.sv */
`timescale 1ns/1ns
// ====================
// Self-checking bench for the serial flash read unit.
module sfr_read_unit_tb;
  import sfr_pkg::*;
  // Density code handed to the unit; the value is arbitrary.
  localparam logic [2:0] DENS = 3'h6;
  // Host pause at a burst read boundary in system clocks; a plain default.
  localparam int BURST_BOUNDARY_DELAY = 20;
  logic clk, rst_n, busy_i, comp_i, buf_wr_i, buf_wsel_i;
  logic cs_n, sck, si, so_q, so_oe_q, mem_rd_q;
  logic [9:0] buf_waddr_i, mem_byte_q;
  logic [7:0] buf_wdata_i, mem_rdata_i, r;
  logic [11:0] mem_page_q, p;
  logic [7:0] ops [10] = '{OP_STAT_A, OP_STAT_B, OP_BUF1_A, OP_BUF1_B, OP_BUF2_A,
    OP_BUF2_B, OP_PAGE_A, OP_PAGE_B, OP_ARRAY_A, OP_ARRAY_B};
  int miscompares = 0;
  int n_compared = 0;
  wire so_pin = so_oe_q ? so_q : 1'bz;

  sfr_read_unit #(.DENSITY_CODE(DENS)) uut (.clk(clk), .rst_n(rst_n), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_q(so_q), .so_oe_q(so_oe_q), .mem_rd_q(mem_rd_q),
    .mem_page_q(mem_page_q), .mem_byte_q(mem_byte_q), .mem_rdata_i(mem_rdata_i),
    .buf_wr_i(buf_wr_i), .buf_wsel_i(buf_wsel_i), .buf_waddr_i(buf_waddr_i),
    .buf_wdata_i(buf_wdata_i), .busy_i(busy_i), .comp_mismatch_i(comp_i));
  sfr_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));

  // System clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Memory pattern by page and byte.
  function automatic logic [7:0] pat(input logic [11:0] pg, input logic [9:0] b);
    return b[7:0] ^ {pg[3:0], 2'b00, b[9:8]};
  endfunction
  // Buffer pattern by buffer and byte.
  function automatic logic [7:0] bufv(input logic s, input logic [9:0] b);
    return b[7:0] ^ (s ? 8'h22 : 8'h11);
  endfunction
  // Byte order 526, 527, 0, 1 around the buffer end.
  function automatic logic [9:0] wrap4(input int k);
    return k[1] ? {9'h000, k[0]} : 10'd526 + 10'(k[0]);
  endfunction
  // Expected state byte from the live inputs.
  function automatic logic [7:0] stat();
    return {~busy_i, comp_i, DENS, 3'h0};
  endfunction

  // Main memory answers half a clock after each strobe, on the next falling edge, otherwise it shows the inverse.
  always @(negedge clk) begin
    mem_rdata_i <= mem_rd_q ? pat(mem_page_q, mem_byte_q) : ~pat(mem_page_q, mem_byte_q);
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Opcode, three address bytes, then dummy bytes.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd);
    host.start();
    host.xfer(8, op, r);
    for (int k = 2; k >= 0; k--) host.xfer(8, a[k*8 +: 8], r);
    repeat (nd) host.xfer(8, 8'h00, r);
  endtask
  // Reads one data byte and compares it.
  task automatic rd(input logic [7:0] exp);
    host.xfer(8, 8'hff, r);
    chk(r, exp);
  endtask
  // Ends the frame and expects the output released.
  task automatic fin();
    host.stop();
    chk({7'h00, so_oe_q}, 8'h00);
  endtask
  // Prints the counts and the verdict.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // Test sequence.
  initial begin
    rst_n = 1'b0;
    busy_i = 1'b0;
    comp_i = 1'b0;
    buf_wr_i = 1'b0;
    buf_wsel_i = 1'b0;
    buf_waddr_i = 10'h000;
    buf_wdata_i = 8'h00;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    host.gap(4);
    for (int j = 0; j < 2; j++) begin
      busy_i = j[0];
      comp_i = ~j[0];
      host.start();
      host.xfer(8, ops[j], r);
      rd(stat());
      busy_i = ~busy_i;
      comp_i = ~comp_i;
      rd(stat());
      fin();
    end
    busy_i = 1'b1;
    host.start();
    host.xfer(8, ops[0], r);
    host.xfer(1, 8'hff, r);
    chk(r, 8'h00);
    busy_i = 1'b0;
    host.gap(3);
    chk({so_pin, 7'h00}, 8'h80);
    fin();
    $display("status tests done");
    cmd(8'h00, 24'h000000, 4);
    host.xfer(8, 8'hff, r);
    chk({7'h00, so_oe_q}, 8'h00);
    fin();
    $display("unknown opcode test done");
    for (int k = 0; k < 8; k++) begin
      buf_wr_i = 1'b1;
      buf_wsel_i = k[2];
      buf_waddr_i = wrap4(k);
      buf_wdata_i = bufv(k[2], wrap4(k));
      host.gap(1);
    end
    buf_wr_i = 1'b0;
    for (int j = 0; j < 2; j++) begin
      p = 12'h005 + 12'(j);
      cmd(ops[6 + j], {2'b11, p, LAST_BYTE}, 4);
      rd(pat(p, LAST_BYTE));
      rd(pat(p, 10'h000));
      rd(pat(p, 10'h001));
      fin();
    end
    $display("page read tests done");
    for (int j = 0; j < 2; j++) begin
      p = j[0] ? LAST_PAGE : 12'h007;
      cmd(ops[8 + j], {2'b00, p, 10'd526}, 4);
      rd(pat(p, 10'd526));
      rd(pat(p, LAST_BYTE));
      host.gap(BURST_BOUNDARY_DELAY);
      rd(pat(p + 12'h001, 10'h000));
      fin();
    end
    $display("array read tests done");
    for (int j = 0; j < 4; j++) begin
      cmd(ops[2 + j], {14'h0000, 10'd526}, 1);
      for (int k = 0; k < 4; k++) rd(bufv(j[1], wrap4(k)));
      fin();
    end
    $display("buffer read tests done");
    end_sim();
  end
endmodule
